// >>> cis_pkg.sv
// Overview of operation
// R1: any reset leaves servicing disabled
// R2: redirect needs global, own, group enables; the pin source redirects without the group enable
// R3: flags set regardless of any enable
// R4: entry flushes, clears enable, pushes, saves, vectors
// R5: events during handler only set flags
// R6: pending event served once enable returns
// R7: return pops, restores context, sets enable
// R8: handler polls and clears flags before return
// R9: synchronous latency three or four cycles
// R10: asynchronous latency three to five cycles
// R11: latency independent of instruction length
// R12: pin flag set Q4-Q1, sampled Q1
// R13: software enables sources before sleeping
// R14: wake vectors if enabled, else continues
// R15: instruction after sleep executes before handler
// R16: edge select one rising, zero falling
// R17: selected edge sets pin flag, may redirect
// R18: entry copies core context into shadows
// R19: exit restores context from shadow copies
// R20: shadows readable and writable in bank 31
// R21: pin synchronised two stages before detection
`default_nettype none

package cis_pkg;

  // bus geometry
  localparam int unsigned ADR_W         = 8;
  localparam int unsigned PC_W          = 15;
  localparam int unsigned SHADOW_N      = 8;

  // register byte offsets
  localparam logic [7:0] OFF_CONTROL    = 8'h00;
  localparam logic [7:0] OFF_PERIPH_EN  = 8'h04;
  localparam logic [7:0] OFF_PERIPH_FLG = 8'h08;
  localparam logic [7:0] OFF_OPTION     = 8'h0C;
  localparam logic [7:0] OFF_SHADOW     = 8'h40;

  // control register fields
  localparam int unsigned BIT_GIE       = 7;
  localparam int unsigned BIT_PERIPHERAL_GROUP_ENABLE      = 6;
  localparam int unsigned BIT_EXT_PIN_IRQ_ENABLE      = 4;
  localparam int unsigned BIT_EXT_PIN_IRQ_FLAG      = 1;
  // option register field
  localparam int unsigned BIT_EDGE_SEL  = 6;

  // reset values
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic       RST_EDGE_SEL   = 1'b1;

  // status shadow keeps all but timeout and power-down
  localparam logic [7:0] STATUS_SAVE_MASK = 8'hE7;
  localparam int unsigned SHADOW_STATUS = 1;

  localparam logic [PC_W-1:0] VECTOR_ADDR = 15'h0004;

  // timing
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned Q_PER_CYCLE   = 4;
  localparam logic [1:0]  Q1_PHASE      = 2'h0;

  typedef enum logic [5:0] {
    CIS_IDLE   = 6'b000001,
    CIS_HOLD_A = 6'b000010,
    CIS_HOLD_B = 6'b000100,
    CIS_FLUSH  = 6'b001000,
    CIS_PUSH   = 6'b010000,
    CIS_VEC    = 6'b100000
  } cis_state_t;

endpackage

`default_nettype wire

// >>> cis_ext_edge.sv
`default_nettype none

module cis_ext_edge (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  input  wire logic rise_sel_i,
  output logic      edge_o
);

  logic sync1_q;
  logic sync2_q;
  logic hist_q;
  logic [1:0] warm_q;
  logic warm_w;

  // two-stage synchroniser then history stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      hist_q  <= 1'b0;
    end else begin
      sync1_q <= pin_i; // R21
      sync2_q <= sync1_q; // R21
      hist_q  <= sync2_q;
    end
  end

  // warm-up after reset, so the pin's idle level never reads as an edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      warm_q <= 2'h0;
    end else if (warm_q != 2'h3) begin
      warm_q <= warm_q + 2'h1; // R21
    end
  end
  assign warm_w = (warm_q == 2'h3);

  // one pulse per selected edge
  always_comb begin
    if (rise_sel_i) begin
      edge_o = warm_w & sync2_q & ~hist_q; // R16
    end else begin
      edge_o = warm_w & ~sync2_q & hist_q; // R16
    end
  end

endmodule

`default_nettype wire

// >>> cis_irq_sequencer.sv
`default_nettype none

module cis_irq_sequencer
  import cis_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // classic wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // event sources
  input  wire logic             ext_pin_i,
  input  wire logic [7:0]       periph_event_i,
  // core sequencer
  input  wire logic             sleep_i,
  input  wire logic             return_from_interrupt_i,
  input  wire logic [7:0]       ctx_w_i,
  input  wire logic [7:0]       ctx_status_i,
  input  wire logic [7:0]       ctx_bsr_i,
  input  wire logic [7:0]       ctx_fsr0l_i,
  input  wire logic [7:0]       ctx_fsr0h_i,
  input  wire logic [7:0]       ctx_fsr1l_i,
  input  wire logic [7:0]       ctx_fsr1h_i,
  input  wire logic [7:0]       ctx_pc_high_latch_i,
  output logic                  q1_o,
  output logic                  flush_o,
  output logic                  push_pc_o,
  output logic                  vector_load_o,
  output logic      [PC_W-1:0]  vector_addr_o,
  output logic                  restore_o,
  output logic                  wake_o,
  output logic      [7:0]       ctx_w_o,
  output logic      [7:0]       ctx_status_o,
  output logic      [7:0]       ctx_bsr_o,
  output logic      [7:0]       ctx_fsr0l_o,
  output logic      [7:0]       ctx_fsr0h_o,
  output logic      [7:0]       ctx_fsr1l_o,
  output logic      [7:0]       ctx_fsr1h_o,
  output logic      [7:0]       ctx_pc_high_latch_o
);

  cis_state_t  state_q;
  logic [1:0]  phase_q;
  logic        q1_w;
  logic        gie_q;
  logic        peripheral_group_enable_q;
  logic        ext_pin_irq_enable_q;
  logic        ext_pin_irq_flag_q;
  logic        edge_sel_q;
  logic [7:0]  pen_q;
  logic [7:0]  pflag_q;
  logic [7:0]  shadow_q [SHADOW_N];
  logic [7:0]  ctx_in [SHADOW_N];
  logic        sleep_q;
  logic        sleep_fall_w;
  logic        ext_edge_w;
  logic        periph_hit_w;
  logic        ext_hit_w;
  logic        any_hit_w;
  logic        enter_w;
  logic        wr_w;
  logic [7:0]  rd_w;
  logic [7:0]  wbyte_w;

  // register hit by word address
  function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] off);
    hit = (adr[ADR_W-1:2] == off[ADR_W-1:2]);
  endfunction

  // external pin edge detect
  cis_ext_edge u_ext_edge (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pin_i      (ext_pin_i),
    .rise_sel_i (edge_sel_q),
    .edge_o     (ext_edge_w)
  );

  // context inputs gathered for the shadow loop
  assign ctx_in[0] = ctx_w_i;
  assign ctx_in[1] = ctx_status_i & STATUS_SAVE_MASK; // R18
  assign ctx_in[2] = ctx_bsr_i;
  assign ctx_in[3] = ctx_fsr0l_i;
  assign ctx_in[4] = ctx_fsr0h_i;
  assign ctx_in[5] = ctx_fsr1l_i;
  assign ctx_in[6] = ctx_fsr1h_i;
  assign ctx_in[7] = ctx_pc_high_latch_i;

  // restore values straight from the shadow flops
  assign ctx_w_o      = shadow_q[0]; // R19
  assign ctx_status_o = shadow_q[1];
  assign ctx_bsr_o    = shadow_q[2];
  assign ctx_fsr0l_o  = shadow_q[3];
  assign ctx_fsr0h_o  = shadow_q[4];
  assign ctx_fsr1l_o  = shadow_q[5];
  assign ctx_fsr1h_o  = shadow_q[6];
  assign ctx_pc_high_latch_o = shadow_q[7];

  // quarter-phase divider, q1 is a one-cycle enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= Q1_PHASE;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end
  assign q1_w = (phase_q == Q1_PHASE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q1_o <= 1'b0;
    end else begin
      q1_o <= q1_w;
    end
  end

  // enable gating and entry decision
  assign periph_hit_w = peripheral_group_enable_q & (|(pflag_q & pen_q)); // R2
  assign ext_hit_w    = ext_pin_irq_enable_q & ext_pin_irq_flag_q; // R2 R17
  assign any_hit_w    = periph_hit_w | ext_hit_w;
  assign sleep_fall_w = sleep_q & ~sleep_i;
  assign enter_w      = (state_q == CIS_IDLE) & q1_w & gie_q & any_hit_w
                        & ~sleep_i & ~sleep_fall_w; // R2 R5 R6 R12

  // bus access: write lands on the ack edge, low byte lane
  assign wr_w    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign wbyte_w = wb_dat_i[7:0];

  // sleep edge tracking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_i;
    end
  end

  // entry sequencer, one step per instruction cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= CIS_IDLE;
    end else begin
      case (state_q)
        CIS_IDLE: begin
          if (sleep_fall_w) begin
            state_q <= CIS_HOLD_A; // R15
          end else if (enter_w) begin
            state_q <= CIS_FLUSH; // R4 R14
          end
        end
        CIS_HOLD_A: begin
          if (q1_w) begin
            state_q <= CIS_HOLD_B;
          end
        end
        CIS_HOLD_B: begin
          if (q1_w) begin
            state_q <= CIS_IDLE; // R15
          end
        end
        CIS_FLUSH: begin
          if (q1_w) begin
            state_q <= CIS_PUSH;
          end
        end
        CIS_PUSH: begin
          if (q1_w) begin
            state_q <= CIS_VEC;
          end
        end
        CIS_VEC: begin
          if (q1_w) begin
            state_q <= CIS_IDLE;
          end
        end
        default: begin
          state_q <= CIS_IDLE;
        end
      endcase
    end
  end

  // core strobes: entry strobes one cycle each, four cycles apart; restore_o follows the return input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flush_o       <= 1'b0;
      push_pc_o     <= 1'b0;
      vector_load_o <= 1'b0;
      vector_addr_o <= '0;
      restore_o     <= 1'b0;
    end else begin
      flush_o       <= enter_w; // R4 R11
      push_pc_o     <= (state_q == CIS_FLUSH) & q1_w; // R4
      vector_load_o <= (state_q == CIS_PUSH) & q1_w; // R4 R9 R10
      vector_addr_o <= VECTOR_ADDR; // R4
      restore_o     <= return_from_interrupt_i; // R7 R19
    end
  end

  // wake request ignores the global enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= sleep_i & any_hit_w; // R14
    end
  end

  // global enable: entry clears, return sets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gie_q <= 1'b0; // R1
    end else if (enter_w) begin
      gie_q <= 1'b0; // R4 R5
    end else if (return_from_interrupt_i) begin
      gie_q <= 1'b1; // R7
    end else if (wr_w && hit(wb_adr_i, OFF_CONTROL)) begin
      gie_q <= wbyte_w[BIT_GIE];
    end
  end

  // enables and edge select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peripheral_group_enable_q     <= 1'b0;
      ext_pin_irq_enable_q     <= 1'b0;
      pen_q      <= RST_BYTE;
      edge_sel_q <= RST_EDGE_SEL;
    end else if (wr_w) begin
      if (hit(wb_adr_i, OFF_CONTROL)) begin
        peripheral_group_enable_q <= wbyte_w[BIT_PERIPHERAL_GROUP_ENABLE];
        ext_pin_irq_enable_q <= wbyte_w[BIT_EXT_PIN_IRQ_ENABLE];
      end
      if (hit(wb_adr_i, OFF_PERIPH_EN)) begin
        pen_q <= wbyte_w;
      end
      if (hit(wb_adr_i, OFF_OPTION)) begin
        edge_sel_q <= wbyte_w[BIT_EDGE_SEL];
      end
    end
  end

  // flags: hardware set wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_pin_irq_flag_q  <= 1'b0;
      pflag_q <= RST_BYTE;
    end else begin
      if (wr_w && hit(wb_adr_i, OFF_CONTROL)) begin
        ext_pin_irq_flag_q <= wbyte_w[BIT_EXT_PIN_IRQ_FLAG] | ext_edge_w; // R3 R17
      end else if (ext_edge_w) begin
        ext_pin_irq_flag_q <= 1'b1; // R3 R17
      end
      if (wr_w && hit(wb_adr_i, OFF_PERIPH_FLG)) begin
        pflag_q <= wbyte_w | periph_event_i; // R3
      end else begin
        pflag_q <= pflag_q | periph_event_i; // R3
      end
    end
  end

  // shadow copies: entry save, bank 31 access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < SHADOW_N; k++) begin
        shadow_q[k] <= RST_BYTE;
      end
    end else begin
      for (int k = 0; k < SHADOW_N; k++) begin
        if (enter_w) begin
          shadow_q[k] <= ctx_in[k]; // R18
        end else if (wr_w && (wb_adr_i[ADR_W-1:2] == (OFF_SHADOW[ADR_W-1:2] + 6'(k)))) begin
          shadow_q[k] <= wbyte_w; // R20
        end
      end
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    rd_w = 8'h00;
    if (hit(wb_adr_i, OFF_CONTROL)) begin
      rd_w[BIT_GIE]  = gie_q;
      rd_w[BIT_PERIPHERAL_GROUP_ENABLE] = peripheral_group_enable_q;
      rd_w[BIT_EXT_PIN_IRQ_ENABLE] = ext_pin_irq_enable_q;
      rd_w[BIT_EXT_PIN_IRQ_FLAG] = ext_pin_irq_flag_q;
    end else if (hit(wb_adr_i, OFF_PERIPH_EN)) begin
      rd_w = pen_q;
    end else if (hit(wb_adr_i, OFF_PERIPH_FLG)) begin
      rd_w = pflag_q;
    end else if (hit(wb_adr_i, OFF_OPTION)) begin
      rd_w[BIT_EDGE_SEL] = edge_sel_q;
    end else begin
      for (int k = 0; k < SHADOW_N; k++) begin
        if (wb_adr_i[ADR_W-1:2] == (OFF_SHADOW[ADR_W-1:2] + 6'(k))) begin
          rd_w = shadow_q[k]; // R20
        end
      end
    end
  end

  // ack one cycle after the request, data registered with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= {24'h000000, rd_w};
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence entry_steps_s;
    flush_o ##4 push_pc_o ##4 vector_load_o;
  endsequence

  chk_reset_disables: assert property ($past(rst_i) |-> !gie_q && !flush_o) // R1
    else $error("servicing enabled after reset");
  chk_entry_gated: assert property (flush_o |-> $past(gie_q && any_hit_w)) // R2
    else $error("entry without enables");
  chk_flag_latch: assert property ((periph_event_i != 8'h00)
      |=> ((pflag_q & $past(periph_event_i)) == $past(periph_event_i))) // R3
    else $error("event flag lost");
  chk_entry_order: assert property (flush_o |-> entry_steps_s) // R4 R9
    else $error("entry steps out of order");
  chk_gie_cleared: assert property (flush_o |-> !gie_q ##1 !flush_o [*7]) // R5
    else $error("global enable kept or reentry");
  chk_pending_served: assert property (enter_w |=> flush_o && !gie_q) // R6
    else $error("pending event not served");
  chk_return_restore: assert property (return_from_interrupt_i && !enter_w
      |=> gie_q && restore_o) // R7
    else $error("return did not restore");
  chk_vector_addr: assert property (vector_load_o |-> vector_addr_o == VECTOR_ADDR) // R4
    else $error("wrong vector");
  chk_pin_flag: assert property (ext_edge_w |=> ext_pin_irq_flag_q) // R17
    else $error("pin edge missed");
  chk_shadow_save: assert property (flush_o |-> shadow_q[SHADOW_STATUS] ==
      ($past(ctx_status_i) & STATUS_SAVE_MASK)) // R18
    else $error("status shadow wrong");
  chk_wake_hold: assert property ($fell(sleep_i) |-> !flush_o [*5]) // R15
    else $error("entry before post-sleep instruction");

endmodule

`default_nettype wire

// >>> cis_core_model.sv
`default_nettype none

module cis_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        load_i,
  input  wire logic [63:0] live_d_i,
  input  wire logic        restore_i,
  input  wire logic [63:0] shadow_i,
  output logic      [63:0] live_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // live core context: handler edits it, return reloads it from the shadows
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      live_o <= 64'h0;
    end else if (restore_i) begin
      live_o <= shadow_i;
    end else if (load_i) begin
      live_o <= live_d_i;
    end
  end
endmodule

`default_nettype wire

// >>> cis_irq_sequencer_bench.sv
`default_nettype none

module cis_irq_sequencer_bench
  import cis_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, we = 1'b0, pin = 1'b0, slp = 1'b0, ret = 1'b0, ld = 1'b0;
  logic [7:0]  adr = 8'h00, ev = 8'h00, m;
  logic [31:0] wd = 32'h0, rdat, r, x, seed = 32'h0000000F;
  logic [63:0] ldd = 64'h0, live, cap;
  wire  [63:0] sh;
  logic        ack, fl, pu, vl, rs, wk, q1;
  logic [14:0] va;
  logic [4:0]  pv;
  int          err_count = 0, tests_run = 0, ncyc = 0, n;

  assign pv = {rs, wk, vl, pu, fl};

  always #12.5 clk_i = ~clk_i;

  cis_irq_sequencer DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_pin_i(pin), .periph_event_i(ev), .sleep_i(slp), .return_from_interrupt_i(ret),
    .ctx_w_i(live[7:0]), .ctx_status_i(live[15:8]), .ctx_bsr_i(live[23:16]),
    .ctx_fsr0l_i(live[31:24]), .ctx_fsr0h_i(live[39:32]), .ctx_fsr1l_i(live[47:40]),
    .ctx_fsr1h_i(live[55:48]), .ctx_pc_high_latch_i(live[63:56]), .q1_o(q1), .flush_o(fl),
    .push_pc_o(pu), .vector_load_o(vl), .vector_addr_o(va), .restore_o(rs), .wake_o(wk),
    .ctx_w_o(sh[7:0]), .ctx_status_o(sh[15:8]), .ctx_bsr_o(sh[23:16]),
    .ctx_fsr0l_o(sh[31:24]), .ctx_fsr0h_o(sh[39:32]), .ctx_fsr1l_o(sh[47:40]),
    .ctx_fsr1h_o(sh[55:48]), .ctx_pc_high_latch_o(sh[63:56])
  );

  cis_core_model core (
    .clk_i(clk_i), .rst_i(rst_i), .load_i(ld), .live_d_i(ldd), .restore_i(rs),
    .shadow_i(sh), .live_o(live)
  );

  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected shadow byte; status loses timeout and power-down
  function automatic logic [31:0] sh_exp(input int i);
    logic [7:0] b;
    b = live[8*i +: 8];
    if (i == 1) begin
      b = b & STATUS_SAVE_MASK;
    end
    return {24'h0, b};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one classic cycle, held until ack, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(r, e);
  endtask

  // edges until pulse k is sampled high; lim when never
  task automatic see(input int k, input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (pv[k] !== 1'b1 && c < lim);
  endtask

  task automatic evt(input logic [7:0] e);
    ev <= e;
    @(posedge clk_i);
    ev <= 8'h00;
  endtask

  task automatic rfi();
    ret <= 1'b1;
    @(posedge clk_i);
    ret <= 1'b0;
  endtask

  task automatic live_set();
    logic [31:0] a;
    a = rnd();
    x = rnd();
    ldd <= {a, x};
    ld <= 1'b1;
    @(posedge clk_i);
    ld <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk_i) begin
    ncyc <= ncyc + 1;
    if (ncyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(OFF_CONTROL, 32'h0);
    rd(OFF_OPTION, 32'h40);
    rd(8'h80, 32'h0);
    $display("reset test done");
    // pending event, late enable, entry, context save and return
    x = rnd();
    m = 8'h01 << x[2:0];
    live_set();
    wb(1'b1, OFF_PERIPH_EN, {24'h0, m});
    evt(m);
    rd(OFF_PERIPH_FLG, {24'h0, m});
    wb(1'b1, OFF_CONTROL, 32'h40);
    see(0, 12, n);
    chk(n, 12);
    wb(1'b1, OFF_CONTROL, 32'hC0);
    see(0, 12, n);
    chk(n < 12, 1);
    chk(q1, 1'b1);
    see(1, 8, n);
    chk(n, 4);
    see(2, 8, n);
    chk(n, 4);
    chk(va, VECTOR_ADDR);
    rd(OFF_CONTROL, 32'h40);
    cap = live & {48'hFFFF_FFFF_FFFF, STATUS_SAVE_MASK, 8'hFF};
    for (int i = 0; i < 8; i++) begin
      rd(8'(OFF_SHADOW + 4 * i), sh_exp(i));
    end
    evt(~m);
    see(0, 12, n);
    chk(n, 12);
    rd(OFF_PERIPH_FLG, 32'hFF);
    live_set();
    x = rnd();
    wb(1'b1, OFF_SHADOW, {24'h0, x[7:0]});
    rd(OFF_SHADOW, {24'h0, x[7:0]});
    wb(1'b1, OFF_PERIPH_FLG, 32'h0);
    rfi();
    see(4, 4, n);
    chk(n, 1);
    @(posedge clk_i);
    chk(live[7:0], x[7:0]);
    chk(live[63:32], cap[63:32]);
    chk({8'h00, live[31:8]}, {8'h00, cap[31:8]});
    rd(OFF_CONTROL, 32'hC0);
    $display("entry test done");
    // group enable missing
    wb(1'b1, OFF_CONTROL, 32'h80);
    evt(m);
    see(0, 12, n);
    chk(n, 12);
    wb(1'b1, OFF_PERIPH_FLG, 32'h0);
    // latency from random offsets
    wb(1'b1, OFF_CONTROL, 32'hC0);
    for (int k = 0; k < 4; k++) begin
      x = rnd();
      repeat (x[2:0]) @(posedge clk_i);
      evt(m);
      see(2, 24, n);
      chk(n >= 7 && n <= 15, 1);
      wb(1'b1, OFF_PERIPH_FLG, 32'h0);
      rfi();
    end
    $display("latency test done");
    // pin edge select, single flag, redirect
    wb(1'b1, OFF_PERIPH_EN, 32'h0);
    for (int s = 0; s < 2; s++) begin
      pin <= ~s[0];
      wb(1'b1, OFF_OPTION, {25'h0, s[0], 6'h0});
      repeat (6) @(posedge clk_i);
      wb(1'b1, OFF_CONTROL, 32'h0);
      pin <= s[0];
      repeat (6) @(posedge clk_i);
      rd(OFF_CONTROL, 32'h02);
      wb(1'b1, OFF_CONTROL, 32'h0);
      pin <= ~s[0];
      repeat (6) @(posedge clk_i);
      rd(OFF_CONTROL, 32'h0);
      wb(1'b1, OFF_CONTROL, 32'h90);
      pin <= s[0];
      see(2, 30, n);
      chk(n <= 20, 1);
      rd(OFF_CONTROL, 32'h12);
      wb(1'b1, OFF_CONTROL, 32'h0);
    end
    $display("pin test done");
    // wake with and without global enable
    for (int g = 1; g >= 0; g--) begin
      wb(1'b1, OFF_PERIPH_EN, {24'h0, m});
      wb(1'b1, OFF_CONTROL, g[0] ? 32'hC0 : 32'h40);
      slp <= 1'b1;
      evt(m);
      see(3, 6, n);
      chk(n < 6, 1);
      see(0, 12, n);
      chk(n, 12);
      slp <= 1'b0;
      see(0, 4, n);
      chk(n, 4);
      see(0, 16, n);
      chk(n < 16, g[0]);
      wb(1'b1, OFF_PERIPH_FLG, 32'h0);
      wb(1'b1, OFF_CONTROL, 32'h0);
    end
    $display("sleep test done");
    // reset in mid-run
    wb(1'b1, OFF_CONTROL, 32'hD0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(OFF_CONTROL, 32'h0);
    repeat (4) @(posedge clk_i);
    rd(OFF_CONTROL, 32'h0);
    $display("rerun reset test done");
    end_of_test();
  end
endmodule

`default_nettype wire
